//--- lsgc_top.v
// Six-channel low-side gate command logic with Avalon-MM register slave
`timescale 1ns/1ns
`include "lsgc_defs.vh"
module lsgc_top #(
    parameter NUM_CH = 6
) (
    // Clock, reset and enable
    input  wire              mclk,
    input  wire              rst_n,
    input  wire              clk_en,
    // Avalon-MM slave
    input  wire [11:0]       avs_address,
    input  wire              avs_read,
    input  wire              avs_write,
    input  wire [31:0]       avs_writedata,
    input  wire [3:0]        avs_byteenable,
    output reg  [31:0]       avs_readdata,
    output reg               avs_waitrequest,
    // Permission inputs from pins and monitors
    input  wire              permit_pin,
    input  wire              gate_supply_low,
    input  wire              logic_supply_low,
    input  wire              clock_present,
    // Requests from channel sequencing logic
    input  wire [NUM_CH-1:0] chan_request,
    // Gate outputs
    output reg  [NUM_CH-1:0] gate_q
);

    // Channels that carry the permit bypass
    localparam [5:0] BYPASS_MASK = `LSGC_BYPASS_MASK;

    // Register state
    reg  [15:0]       drv_setup_q;     // driver_setup contents
    reg  [15:0]       drv_setup_d;     // Next value of driver_setup
    reg  [3:0]        event_q;         // Sticky shutdown causes
    reg  [3:0]        event_d;         // Next value of the sticky causes

    // Bus decode
    wire              bus_req;         // Read or write is pending
    wire              bus_commit;      // Edge at which the master sees the answer
    wire              hit_setup;       // driver_setup addressed
    wire              hit_status;      // Status register addressed
    wire              hit_event;       // Event register addressed
    reg  [31:0]       rd_value;        // Read data mux

    // Synchronised permissions
    wire [3:0]        raw_inputs;      // Pin levels before sync
    wire [3:0]        sync_inputs;     // Pin levels after sync
    wire              permit_ok;       // Driver permit present
    wire              gate_uv;         // Gate supply undervoltage
    wire              logic_uv;        // Logic supply undervoltage
    wire              clock_ok;        // System clock present
    wire [3:0]        event_set;       // Shutdown causes seen this cycle

    // Commands
    wire [NUM_CH-1:0] gate_cmd;        // Combinational gate commands

    // Byte-lane merge of a 16-bit register with bus write data
    function [15:0] lane_merge;
        input [15:0] old_val;
        input [31:0] wdata;
        input [3:0]  be;
        begin
            lane_merge[7:0]  = be[0] ? wdata[7:0]  : old_val[7:0];
            lane_merge[15:8] = be[1] ? wdata[15:8] : old_val[15:8];
        end
    endfunction

    // Word-aligned match of a byte address with a register index
    function reg_hit;
        input [11:0] addr;
        input [9:0]  idx;
        begin
            reg_hit = (addr[1:0] == 2'h0) && (addr[11:2] == idx);
        end
    endfunction

    // Gather the asynchronous levels in event-bit order
    assign raw_inputs[`LSGC_EV_PERMIT_LOST] = permit_pin;
    assign raw_inputs[`LSGC_EV_GATE_UV]     = gate_supply_low;
    assign raw_inputs[`LSGC_EV_LOGIC_UV]    = logic_supply_low;
    assign raw_inputs[`LSGC_EV_CLOCK_LOST]  = clock_present;

    // Two flip-flops on every pin level; reset value is the safe one
    lsgc_sync2 #(
        .WIDTH   (4),
        .RST_VAL (`LSGC_RST_SYNC)
    ) u_sync (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .async_in (raw_inputs),
        .sync_out (sync_inputs)
    );

    assign permit_ok = sync_inputs[`LSGC_EV_PERMIT_LOST];
    assign gate_uv   = sync_inputs[`LSGC_EV_GATE_UV];
    assign logic_uv  = sync_inputs[`LSGC_EV_LOGIC_UV];
    assign clock_ok  = sync_inputs[`LSGC_EV_CLOCK_LOST];

    // One command term per channel, each independent of the others
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch = ch + 1)
        begin : g_chan
            lsgc_chan #(
                .BYPASS_ABLE (BYPASS_MASK[ch])
            ) u_chan (
                .chan_request      (chan_request[ch]),
                .permit_ok         (permit_ok),
                .gate_supply_low   (gate_uv),
                .logic_supply_low  (logic_uv),
                .clock_ok          (clock_ok),
                .permit_bypass_bit (drv_setup_q[`LSGC_BIT_PERMIT_BYPASS]),
                .clk_check_en      (drv_setup_q[`LSGC_BIT_CLK_CHECK_EN]),
                .gate_cmd          (gate_cmd[ch])
            );
        end
    endgenerate

    // Gate output stage: reset clears it at once, otherwise follows the command on edges with clk_en high
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gate_q <= {NUM_CH{1'b0}};
        end
        else if (clk_en)
        begin
            // High drives the gate toward supply, low toward power_ground
            gate_q <= gate_cmd;
        end
    end

    // Bus request and the edge at which it completes
    assign bus_req    = avs_read | avs_write;
    assign bus_commit = bus_req & ~avs_waitrequest;

    // Address decode
    assign hit_setup  = reg_hit(avs_address, `LSGC_IDX_DRV_SETUP);
    assign hit_status = reg_hit(avs_address, `LSGC_IDX_STATUS);
    assign hit_event  = reg_hit(avs_address, `LSGC_IDX_EVENT);

    // Read mux; unmapped addresses read as zero
    always @*
    begin
        rd_value = 32'h0000_0000;
        if (hit_setup)
        begin
            rd_value[15:0] = drv_setup_q;
        end
        else if (hit_status)
        begin
            // Live gate state, synchronised inputs and requests
            rd_value[`LSGC_STS_GATE_LSB +: NUM_CH]  = gate_q;
            rd_value[`LSGC_STS_INPUT_LSB +: 4]      = sync_inputs;
            rd_value[`LSGC_STS_REQ_LSB +: NUM_CH]   = chan_request;
        end
        else if (hit_event)
        begin
            rd_value[3:0] = event_q;
        end
    end

    // Shutdown causes seen at the synchronised inputs
    assign event_set[`LSGC_EV_PERMIT_LOST] = ~permit_ok;
    assign event_set[`LSGC_EV_GATE_UV]     = gate_uv;
    assign event_set[`LSGC_EV_LOGIC_UV]    = logic_uv;
    assign event_set[`LSGC_EV_CLOCK_LOST]  = ~clock_ok;

    // Next register values: writes land only at the completing edge
    always @*
    begin
        drv_setup_d = drv_setup_q;
        event_d     = event_q;
        if (bus_commit && avs_write && hit_setup)
        begin
            drv_setup_d = lane_merge(drv_setup_q, avs_writedata, avs_byteenable);
        end
        if (bus_commit && avs_write && hit_event && avs_byteenable[0])
        begin
            // Write one to clear
            event_d = event_q & ~avs_writedata[3:0];
        end
        // A cause present in the clearing cycle stays recorded
        event_d = event_d | event_set;
    end

    // Register file storage
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            drv_setup_q <= `LSGC_RST_DRV_SETUP;
            event_q     <= `LSGC_RST_EVENT;
        end
        else if (clk_en)
        begin
            drv_setup_q <= drv_setup_d;
            event_q     <= event_d;
        end
    end

    // Bus handshake: one wait cycle, then the answer for one cycle
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            if (bus_req && avs_waitrequest)
            begin
                // First cycle of a request: capture read data, drop wait
                avs_waitrequest <= 1'b0;
                if (avs_read)
                begin
                    avs_readdata <= rd_value;
                end
            end
            else
            begin
                // Completed or idle: wait stands high for the next request
                avs_waitrequest <= 1'b1;
            end
        end
    end

endmodule

//--- lsgc_defs.vh
// Constants for the six-channel low-side gate command logic
//
// Functional notes
// - Six independent channels, own request and command.
// - Power-on reset holds every gate output off.
// - Channel request is one term of command.
// - Dropped driver permit forces affected gates off.
// - Channels 3 and 6 may bypass permit.
// - Bypass bit set: channels 3, 6 ignore permit.
// - Either supply undervoltage forces every gate off.
// - Missing system clock forces every gate off.
// - Clock-loss shutdown can be disabled by configuration.
// - Command high only when all permissions and request.
// - Command high drives gate output high.
// - Command low drives gate output low.
// - Any reset forces gates low without clock.
`ifndef LSGC_DEFS_VH
`define LSGC_DEFS_VH

// Register indices; byte address is four times the index
`define LSGC_IDX_DRV_SETUP     10'h1c5
`define LSGC_IDX_STATUS        10'h1c6
`define LSGC_IDX_EVENT         10'h1c7

// Field positions in driver_setup
`define LSGC_BIT_PERMIT_BYPASS 0
`define LSGC_BIT_CLK_CHECK_EN  1

// Field positions in the status register
`define LSGC_STS_GATE_LSB      0
`define LSGC_STS_INPUT_LSB     8
`define LSGC_STS_REQ_LSB       16

// Event bit positions, also order of the synchronised inputs
`define LSGC_EV_PERMIT_LOST    0
`define LSGC_EV_GATE_UV        1
`define LSGC_EV_LOGIC_UV       2
`define LSGC_EV_CLOCK_LOST     3

// Reset values
`define LSGC_RST_DRV_SETUP     16'h0002
`define LSGC_RST_EVENT         4'h0
`define LSGC_RST_SYNC          4'h6

// Channels able to bypass the permit input (channels 3 and 6)
`define LSGC_BYPASS_MASK       6'h24

`endif

//--- lsgc_sync2.v
// Two-stage synchroniser for a vector of asynchronous levels
`timescale 1ns/1ns
module lsgc_sync2 #(
    parameter           WIDTH   = 4,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
    // Clock, reset and enable
    input  wire             mclk,
    input  wire             rst_n,
    input  wire             clk_en,
    // Levels in and out
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_q;    // First stage, read only by the second
    reg [WIDTH-1:0] stable_q;  // Second stage, safe to use

    // Shift the level through two flip-flops; reset goes to the safe value
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q   <= RST_VAL;
            stable_q <= RST_VAL;
        end
        else if (clk_en)
        begin
            meta_q   <= async_in;
            stable_q <= meta_q;
        end
    end

    assign sync_out = stable_q;

endmodule

//--- lsgc_chan.v
// Gate command term of one low-side channel
`timescale 1ns/1ns
module lsgc_chan #(
    parameter BYPASS_ABLE = 0
) (
    // Request from channel sequencing logic
    input  wire chan_request,
    // Permissions
    input  wire permit_ok,
    input  wire gate_supply_low,
    input  wire logic_supply_low,
    input  wire clock_ok,
    // Configuration
    input  wire permit_bypass_bit,
    input  wire clk_check_en,
    // Command
    output wire gate_cmd
);

    wire permit_term;  // Permit after optional bypass
    wire clock_term;   // Clock presence after optional disable

    // Only channels built with bypass can ignore a dropped permit
    assign permit_term = permit_ok | ((BYPASS_ABLE != 0) & permit_bypass_bit);

    // Clock loss only counts while the check is enabled
    assign clock_term  = clock_ok | ~clk_check_en;

    // All permissions and the request together, no storage in between
    assign gate_cmd = permit_term & ~gate_supply_low & ~logic_supply_low
                    & clock_term & chan_request;

endmodule

//--- lsgc_chk.sv
// Checker for the low-side gate command block
`timescale 1ns/1ns
`include "lsgc_defs.vh"
module lsgc_chk #(
    parameter NUM_CH = 6
) (
    // Clock, reset, enable
    input wire              mclk,
    input wire              rst_n,
    input wire              clk_en,
    // Register bus
    input wire [11:0]       avs_address,
    input wire              avs_read,
    input wire              avs_write,
    input wire [31:0]       avs_writedata,
    input wire [3:0]        avs_byteenable,
    input wire [31:0]       avs_readdata,
    input wire              avs_waitrequest,
    // Permissions, requests, gates
    input wire              permit_pin,
    input wire              gate_supply_low,
    input wire              logic_supply_low,
    input wire              clock_present,
    input wire [NUM_CH-1:0] chan_request,
    input wire [NUM_CH-1:0] gate_q
);
    reg  [1:0]        run_q;   // Consecutive enabled edges, cleared by reset or a disabled edge, saturating
    reg  [15:0]       setup_q; // Shadow of driver_setup
    wire [NUM_CH-1:0] byp = `LSGC_BYPASS_MASK;
    wire              wr_su = avs_write && !avs_waitrequest && clk_en && avs_address == 12'h714;
    // Pipeline fill count and setup shadow
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            run_q   <= 2'h0;
            setup_q <= `LSGC_RST_DRV_SETUP;
        end
        else
        begin
            run_q <= !clk_en ? 2'h0 : (run_q == 2'h3 ? run_q : run_q + 2'h1);
            if (wr_su && avs_byteenable[0])
                setup_q[7:0] <= avs_writedata[7:0];
            if (wr_su && avs_byteenable[1])
                setup_q[15:8] <= avs_writedata[15:8];
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Request taken, then exactly one answer cycle
    sequence s_taken;
        (avs_read || avs_write) && avs_waitrequest && clk_en;
    endsequence
    sequence s_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    a_reset_off: assert property (disable iff (1'b0) !rst_n |-> gate_q == 0)
        else $error("gate on during reset");
    a_gate_truth: assert property (run_q == 2'h3 |-> gate_q == ($past(chan_request) &
        ({NUM_CH{$past(permit_pin, 3)}} | (byp & {NUM_CH{$past(setup_q[0])}})) &
        {NUM_CH{!$past(gate_supply_low, 3) && !$past(logic_supply_low, 3) &&
        ($past(clock_present, 3) || !$past(setup_q[1]))}}))
        else $error("gate command wrong");
    a_permit_off: assert property (run_q == 2'h3 && !$past(permit_pin, 3) |-> (gate_q & ~byp) == 0)
        else $error("gate on without permit");
    a_supply_off: assert property (run_q == 2'h3 && ($past(gate_supply_low, 3) || $past(logic_supply_low, 3))
        |-> gate_q == 0) else $error("gate on in undervoltage");
    a_clock_off: assert property (run_q == 2'h3 && !$past(clock_present, 3) && $past(setup_q[1])
        |-> gate_q == 0) else $error("gate on without clock");
    a_bus_answer: assert property (s_taken |=> s_answer)
        else $error("bus answer timing wrong");
    a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address != 12'h714 &&
        avs_address != 12'h718 && avs_address != 12'h71c |-> avs_readdata == 0) else $error("unmapped read not 0");
    a_setup_read: assert property (avs_read && !avs_waitrequest && avs_address == 12'h714
        |-> avs_readdata == {16'h0, setup_q}) else $error("setup readback wrong");
endmodule
bind lsgc_top lsgc_chk #(.NUM_CH(NUM_CH)) u_chk (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .permit_pin(permit_pin), .gate_supply_low(gate_supply_low), .logic_supply_low(logic_supply_low),
    .clock_present(clock_present), .chan_request(chan_request), .gate_q(gate_q));

//--- lsgc_req_src.sv
// Request source that bounds each channel's switching rate
`timescale 1ns/1ns
module lsgc_req_src #(
    parameter MIN_GAP = 50
) (
    // Clock and reset
    input  wire       mclk,
    input  wire       rst_n,
    // Wanted pattern in, requests out
    input  wire [5:0] want,
    output reg  [5:0] chan_request
);
    integer gap; // Cycles since last change
    // Hold each pattern at least 51 cycles: no faster than 100 kHz at 10 MHz
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            chan_request <= 6'h00;
            gap          <= 0;
        end
        else if (want !== chan_request && gap >= MIN_GAP)
        begin
            chan_request <= want;
            gap          <= 0;
        end
        else if (gap < MIN_GAP)
            gap <= gap + 1;
    end
endmodule

//--- testbench.sv
// Self-checking bench for the low-side gate command block
`timescale 1ns/1ns
module testbench;
    reg         mclk;
    reg         rst_n;
    reg         cen;  // Clock enable of the block
    reg  [11:0] adr;
    reg         rdq;
    reg         wrq;
    reg  [31:0] wd;
    reg  [3:0]  be;
    wire [31:0] avs_readdata;
    wire        avs_waitrequest;
    reg  [3:0]  pins; // Clock ok, logic uv, gate uv, permit
    reg  [5:0]  want; // Pattern asked of the request source
    wire [5:0]  chan_request;
    wire [5:0]  gate_q;
    integer     error_cnt;
    integer     compares;
    integer     i;
    reg  [31:0] rd;
    reg  [23:0] st [0:8]; // Setup, pins, request, gates
    lsgc_top dut (.mclk(mclk), .rst_n(rst_n), .clk_en(cen), .avs_address(adr), .avs_read(rdq),
        .avs_write(wrq), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .permit_pin(pins[0]), .gate_supply_low(pins[1]),
        .logic_supply_low(pins[2]), .clock_present(pins[3]), .chan_request(chan_request), .gate_q(gate_q));
    lsgc_req_src u_req (.mclk(mclk), .rst_n(rst_n), .want(want), .chan_request(chan_request));
    // Clock
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // Verdict
    task finish_test;
    begin
        if (error_cnt == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
    endtask
    task chk(input [31:0] seen, input [31:0] exp);
    begin
        compares = compares + 1;
        if (seen !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    end
    endtask
    // One bus cycle, held until waitrequest is seen low
    task bus(input w, input [11:0] a, input [31:0] d, input [3:0] b);
        integer n;
    begin
        adr <= a;
        wd  <= d;
        be  <= b;
        rdq <= !w;
        wrq <= w;
        n = 0;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0 && n < 20)
        begin
            n = n + 1;
            @(posedge mclk);
        end
        rd = avs_readdata;
        rdq <= 1'b0;
        wrq <= 1'b0;
        @(posedge mclk);
        if (n == 20)
        begin
            error_cnt = error_cnt + 1;
            finish_test;
        end
    end
    endtask
    // Setup register lanes, upper bits and unmapped places
    task test_regs;
    begin
        bus(1'b0, 12'h714, 0, 4'hf);
        chk(rd, 32'h2);
        bus(1'b1, 12'h714, 32'hffffffff, 4'h1);
        bus(1'b0, 12'h714, 0, 4'hf);
        chk(rd, 32'hff);
        bus(1'b1, 12'h714, 32'h12345678, 4'hf);
        bus(1'b0, 12'h714, 0, 4'hf);
        chk(rd, 32'h5678);
        bus(1'b0, 12'h700, 0, 4'hf);
        chk(rd, 32'h0);
        bus(1'b0, 12'h715, 0, 4'hf);
        chk(rd, 32'h0);
    end
    endtask
    // Clock enable low freezes the gates, even against a dropped permit
    task test_freeze;
    begin
        cen  <= 1'b0;
        pins <= 4'h8;
        repeat (10) @(posedge mclk);
        chk(gate_q, 32'h2a);
        cen  <= 1'b1;
        repeat (5) @(posedge mclk);
        chk(gate_q, 32'h20);
        pins <= 4'h9;
        repeat (5) @(posedge mclk);
        chk(gate_q, 32'h2a);
    end
    endtask
    // Sticky shutdown causes: lane 0 clears, a present cause survives the clear
    task test_events;
    begin
        bus(1'b0, 12'h71c, 0, 4'hf);
        chk(rd, 32'hf);
        bus(1'b1, 12'h71c, 32'hf, 4'h2);
        bus(1'b0, 12'h71c, 0, 4'hf);
        chk(rd, 32'hf);
        bus(1'b1, 12'h71c, 32'hf, 4'h1);
        bus(1'b0, 12'h71c, 0, 4'hf);
        chk(rd, 32'h0);
        pins <= 4'h8;
        repeat (5) @(posedge mclk);
        chk(gate_q, 32'h20);
        bus(1'b1, 12'h71c, 32'hf, 4'h1);
        bus(1'b0, 12'h71c, 0, 4'hf);
        chk(rd, 32'h1);
        pins <= 4'h9;
        repeat (5) @(posedge mclk);
    end
    endtask
    // Every shutdown cause, bypass and clock-check settings
    task test_truth;
    begin
        for (i = 0; i < 9; i = i + 1)
        begin
            bus(1'b1, 12'h714, {28'h0, st[i][23:20]}, 4'h3);
            pins <= st[i][19:16];
            want <= st[i][13:8];
            repeat (60) @(posedge mclk);
            chk(gate_q, st[i][5:0]);
            bus(1'b0, 12'h718, 0, 4'hf);
            chk({rd[21:16], rd[11:8], rd[5:0]}, {st[i][13:8], st[i][19:16], st[i][5:0]});
        end
    end
    endtask
    // Reset in mid-run with gates on
    task test_reset;
    begin
        rst_n <= 1'b0;
        #1 chk(gate_q, 32'h0);
        repeat (20) @(posedge mclk);
        chk(gate_q, 32'h0);
        rst_n <= 1'b1;
        @(posedge mclk);
        bus(1'b0, 12'h714, 0, 4'hf);
        chk(rd, 32'h2);
        repeat (60) @(posedge mclk);
        chk(gate_q, 32'h2a);
    end
    endtask
    initial
    begin
        error_cnt = 0;
        compares = 0;
        rst_n = 1'b0;
        cen = 1'b1;
        adr = 0;
        rdq = 0;
        wrq = 0;
        wd = 0;
        be = 0;
        pins = 4'h6;
        want = 0;
        st = '{24'h293f3f, 24'h283f00, 24'h383f24, 24'h3b3f00, 24'h3d3f00,
               24'h313f00, 24'h113f3f, 24'h191515, 24'h192a2a};
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        test_regs;
        test_truth;
        test_freeze;
        test_events;
        test_reset;
        finish_test;
    end
    // Watchdog
    initial
    begin
        repeat (100000) @(posedge mclk);
        error_cnt = error_cnt + 1;
        finish_test;
    end
endmodule
